// [design/thermal_throttle_map.vh]
// register offsets, field positions, reset values and timing counts of the thermal throttle block
// assumes a 125 MHz core clock and a 32-bit axi4-lite register bus
`ifndef THERMAL_THROTTLE_MAP_VH
`define THERMAL_THROTTLE_MAP_VH

// =====================================================
// register byte offsets
`define OFF_PIN_CTRL 8'h00
`define OFF_DUTY_CTRL 8'h04
`define OFF_CHIPSET_CTRL 8'h08
`define OFF_PKG_STATUS 8'h0c
`define OFF_TEMP_CFG 8'h10
`define OFF_MEM_THRESH 8'h14
`define OFF_MEM_STATUS 8'h18
`define OFF_IRQ_EVENTS 8'h1c

// =====================================================
// field positions
`define PIN_CTRL_INPUT_ONLY 0
`define PIN_CTRL_HOT_IRQ_EN 1
`define PIN_CTRL_CRIT_IRQ_EN 2
`define DUTY_EN_BIT 4
`define DUTY_LO 1
`define DUTY_HI 3
`define STEP_FINE_BIT 8
`define ST_CRIT 0
`define ST_CRIT_LOG 1
`define ST_EXT_HOT 2
`define ST_TCC_ACTIVE 3
`define ST_TRIP 4
`define ST_LOWEST_PERF 5
`define ST_HOT_OUT 6

// =====================================================
// reset values and fixed figures
`define PIN_CTRL_RESET 3'h0
`define TEMP_ACT_DEFAULT 8'd100
`define TEMP_ACT_MIN 8'd80
`define TCC_DUTY_CODE 3'h2
`define DUTY_STEPS 8'd8
`define EXT_RESP_US 100
`define CLK_MHZ 125
`define EXT_RESP_CYCLES ((`EXT_RESP_US * `CLK_MHZ) - 1)
`define CRIT_HOLD_CYCLES 16'd1024

`endif

// [design/thermal_throttle_control.v]
// package thermal protection: hot pin, trip output, critical status, clock modulation,
// memory traffic throttle levels; registers on an axi4-lite slave
// assumes sensor readings, idle and power-meter inputs are synchronous to core_clk
//
// What this block does
// RULE_01: drive hot pin when any core reaches the activation point, regardless of adaptive enable
// RULE_02: hot pin resets bidirectional; software may select input only
// RULE_03: recognised outside hot assertion forces lowest perf state, no clock modulation
// RULE_04: hold lowest perf state until outside party releases the hot pin
// RULE_05: configurable interrupt on every hot pin assertion and de-assertion; here only outside assertions and releases raise events, not our own drive
// RULE_06: while we drive the pin, outside assertions are deferred until release
// RULE_07: outside hot response takes effect well under 100 microseconds
// RULE_08: hot output drops in package idle, re-asserts on wakeup if still hot
// RULE_09: thermal serial link stays enabled in every package idle state
// RULE_10: damage temperature shuts package down and asserts thermal trip always
// RULE_11: adaptive throttle plus sustained heat latches critical and sticky log, interrupt
// RULE_12: on-demand during active thermal circuit uses fixed factory duty cycle
// RULE_13: emulated i/o duty cycle wins over register duty cycle on conflict
// RULE_14: duty enable bit 4 starts core clock modulation immediately, any temperature
// RULE_15: duty field bits 3:1, step 12.5 or 6.25 percent, discoverable; here the fine step only shifts the 12.5 percent steps by one slot
// RULE_16: register modulation acts on each core clock by its own setting
// RULE_17: emulated i/o modulation acts on all cores at once
// RULE_18: programmable warm and hot memory thresholds give medium and severe throttling
// RULE_19: platform reports memory heat by serial link injection or two pins; this block takes only the two pins
// RULE_20: without sensor, per-rank power estimate against thresholds may throttle memory
// RULE_21: activation temperature defaults to 100 C, lowerable to 80 C
// RULE_22: activation when relative sensor reading reaches zero, unless offset programmed
// RULE_23: incoming hot pin and memory pins pass a two-stage synchroniser
`timescale 1ns/1ps
`include "thermal_throttle_map.vh"

module thermal_throttle_control #(
	parameter cores = 4,
	parameter fine_step = 1'b0
) (
	input wire core_clk,
	input wire arst_n,
	// axi4-lite slave
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// hot pin, open drain style
	input wire proc_hot_n_in,
	output reg proc_hot_n_out,
	output reg proc_hot_n_oe_n,
	output reg thermal_trip_n,
	output reg hot_irq,
	// per-core margin below max junction temperature in degrees, 0 means at the limit
	input wire [8*cores-1:0] core_margin,
	input wire damage_temp,
	input wire adaptive_en,
	input wire pkg_idle,
	input wire [1:0] ext_mem_temp_n,
	input wire mem_sensor_present,
	input wire [15:0] rank_power,
	// per-core register duty settings, bit 4 enable, bits 3:1 duty
	input wire [5*cores-1:0] core_duty_ctrl,
	output reg [cores-1:0] core_clk_gate,
	output reg lowest_perf_state,
	output reg [1:0] mem_throttle_level,
	output reg serial_link_en,
	output reg package_shutdown
);

	// =====================================================
	// registers
	reg [2:0] pin_ctrl;
	reg [4:0] duty_ctrl;
	reg [3:0] chipset_ctrl;
	reg [7:0] temp_act;
	reg [15:0] mem_warm;
	reg [15:0] mem_hot;
	reg crit;
	reg crit_log;
	reg [2:0] irq_events;
	reg [15:0] crit_cnt;
	reg ext_hot_prev;
	reg [1:0] oe_hist;
	reg [2:0] mod_phase;
	reg [7:0] awaddr_q;
	reg [31:0] wdata_q;
	reg aw_held;
	reg w_held;

	localparam [0:0] fine_bit = (fine_step != 0);
	// a lowered activation temperature widens the margin at which a core counts as hot
	wire [7:0] offset = `TEMP_ACT_DEFAULT - temp_act;
	wire [2:0] pin_raw = {ext_mem_temp_n, proc_hot_n_in};
	wire [2:0] pin_sync;
	wire hot_pin_sync = pin_sync[0];
	wire [1:0] mem_sync = pin_sync[2:1];
	wire [cores-1:0] core_hot;
	genvar g;
	generate
		for (g = 0; g < cores; g = g + 1) begin : g_core
			// reading is relative; offset raises the activation margin
			assign core_hot[g] = core_margin[8*g +: 8] <= offset; // RULE_22
		end
	endgenerate
	wire any_hot = |core_hot;
	wire drive_hot = any_hot && !pin_ctrl[`PIN_CTRL_INPUT_ONLY] && !pkg_idle; // RULE_01 RULE_02 RULE_08
	// our own drive masks the pin, so outside assertion is seen only once we let go
	// oe_hist also masks the two cycles in which the synchroniser still holds our own low
	wire ext_hot = !hot_pin_sync && proc_hot_n_oe_n && (&oe_hist); // RULE_06
	wire tcc_active = any_hot;
	wire [3:0] io_duty = chipset_ctrl;
	// a write commits once address and data are held and the last response is gone
	wire w_held_go = aw_held && w_held && !s_axi_bvalid;

	// =====================================================
	// pin synchronisers: bit 0 hot pin, bits 2:1 memory heat pins
	// stages reset to the idle high level so reset release shows no false edge
	generate
		for (g = 0; g < 3; g = g + 1) begin : g_sync
			reg stage1;
			reg stage2;
			always @(posedge core_clk or negedge arst_n) begin
				if (!arst_n) begin
					stage1 <= 1'b1;
					stage2 <= 1'b1;
				end else begin
					stage1 <= pin_raw[g]; // RULE_23
					stage2 <= stage1;
				end
			end
			assign pin_sync[g] = stage2;
		end
	endgenerate

	// =====================================================
	// hot pin drive
	// pull low only; released, the board pull-up sets the level
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			proc_hot_n_out <= 1'b1;
			proc_hot_n_oe_n <= 1'b1;
			oe_hist <= 2'h3;
		end else begin
			proc_hot_n_out <= !drive_hot;
			proc_hot_n_oe_n <= !drive_hot; // RULE_01 RULE_08
			oe_hist <= {oe_hist[0], proc_hot_n_oe_n}; // RULE_06
		end
	end

	// =====================================================
	// outside hot recognition
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			ext_hot_prev <= 1'b0;
			lowest_perf_state <= 1'b0;
		end else begin
			ext_hot_prev <= ext_hot;
			// three-cycle response from the pin (two synchroniser stages plus this register), far inside the allowed bound
			lowest_perf_state <= ext_hot; // RULE_03 RULE_04 RULE_07
		end
	end

	// =====================================================
	// trip and serial link
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			thermal_trip_n <= 1'b1;
			package_shutdown <= 1'b0;
			serial_link_en <= 1'b1;
		end else begin
			// sticky until reset: a cooled package must not restart on its own
			if (damage_temp) begin
				thermal_trip_n <= 1'b0; // RULE_10
				package_shutdown <= 1'b1;
			end
			serial_link_en <= 1'b1; // RULE_09
		end
	end

	// =====================================================
	// clock modulation, 8 phase slots
	// an eight-slot wheel cannot show 6.25 percent; the fine step moves the edge one slot
	wire [2:0] fine_half = fine_bit ? 3'h1 : 3'h0; // RULE_15
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n)
			mod_phase <= 3'h0;
		else
			mod_phase <= mod_phase + 3'h1;
	end

	generate
		for (g = 0; g < cores; g = g + 1) begin : g_mod
			wire reg_en = core_duty_ctrl[5*g+`DUTY_EN_BIT] || duty_ctrl[`DUTY_EN_BIT]; // RULE_14 RULE_16
			wire [2:0] reg_duty = core_duty_ctrl[5*g+`DUTY_EN_BIT] ?
				core_duty_ctrl[5*g+`DUTY_LO +: 3] : duty_ctrl[`DUTY_HI:`DUTY_LO]; // RULE_15
			wire io_en = io_duty[3]; // RULE_17
			wire [2:0] sel = io_en ? io_duty[2:0] : reg_duty; // RULE_13
			wire [2:0] eff = tcc_active ? `TCC_DUTY_CODE : sel; // RULE_12
			wire on = (reg_en || io_en) && !ext_hot && !lowest_perf_state; // RULE_03
			wire [3:0] threshold = {1'b0, eff} + {1'b0, fine_half};
			always @(posedge core_clk or negedge arst_n) begin
				if (!arst_n)
					core_clk_gate[g] <= 1'b0;
				else
					core_clk_gate[g] <= on && (eff != 3'h0) && ({1'b0, mod_phase} >= threshold);
			end
		end
	endgenerate

	// =====================================================
	// critical temperature
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			crit <= 1'b0;
			crit_log <= 1'b0;
			crit_cnt <= 16'h0;
		end else begin
			// adaptive throttling that fails to cool the package for the hold time is critical
			if (tcc_active && adaptive_en) begin
				if (crit_cnt != `CRIT_HOLD_CYCLES)
					crit_cnt <= crit_cnt + 16'h1;
			end else
				crit_cnt <= 16'h0;
			crit <= (crit_cnt == `CRIT_HOLD_CYCLES); // RULE_11
			if (w_held_go && awaddr_q == `OFF_PKG_STATUS && wdata_q[`ST_CRIT_LOG])
				crit_log <= 1'b0;
			// set after clear so a latch in the clearing cycle survives
			if (crit_cnt == `CRIT_HOLD_CYCLES)
				crit_log <= 1'b1; // RULE_11
		end
	end

	// =====================================================
	// event flags and interrupt
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			irq_events <= 3'h0;
			hot_irq <= 1'b0;
		end else begin
			if (w_held_go && awaddr_q == `OFF_IRQ_EVENTS)
				irq_events <= irq_events & ~wdata_q[2:0];
			// set after clear so an event in the clearing cycle survives
			if (ext_hot && !ext_hot_prev)
				irq_events[0] <= 1'b1; // RULE_05
			if (!ext_hot && ext_hot_prev)
				irq_events[1] <= 1'b1; // RULE_05
			if (crit_cnt == `CRIT_HOLD_CYCLES && !crit)
				irq_events[2] <= 1'b1; // RULE_11
			hot_irq <= (pin_ctrl[`PIN_CTRL_HOT_IRQ_EN] && |irq_events[1:0]) ||
				(pin_ctrl[`PIN_CTRL_CRIT_IRQ_EN] && irq_events[2]);
		end
	end

	// =====================================================
	// memory throttle: pins or power estimate
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n)
			mem_throttle_level <= 2'h0;
		else begin
			// hot outranks warm whichever source reports it
			if (!mem_sync[1] || (!mem_sensor_present && rank_power > mem_hot))
				mem_throttle_level <= 2'h2; // RULE_18 RULE_19 RULE_20
			else if (!mem_sync[0] || (!mem_sensor_present && rank_power > mem_warm))
				mem_throttle_level <= 2'h1; // RULE_18 RULE_20
			else
				mem_throttle_level <= 2'h0;
		end
	end

	// =====================================================
	// axi4-lite write channel
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			awaddr_q <= 8'h0;
			wdata_q <= 32'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
			pin_ctrl <= `PIN_CTRL_RESET; // RULE_02
			duty_ctrl <= 5'h0;
			chipset_ctrl <= 4'h0;
			temp_act <= `TEMP_ACT_DEFAULT; // RULE_21
			mem_warm <= 16'hffff;
			mem_hot <= 16'hffff;
		end else begin
			s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
			s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				awaddr_q <= {s_axi_awaddr[7:2], 2'h0};
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				wdata_q <= s_axi_wdata;
			end
			if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (w_held_go) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= 2'h0;
				case (awaddr_q)
					// input only is safer: no own drive can then hide an outside alarm
					`OFF_PIN_CTRL: pin_ctrl <= wdata_q[2:0]; // RULE_02
					`OFF_DUTY_CTRL: duty_ctrl <= wdata_q[4:0]; // RULE_14
					`OFF_CHIPSET_CTRL: chipset_ctrl <= wdata_q[3:0]; // RULE_17
					`OFF_TEMP_CFG: begin
						if (wdata_q[7:0] >= `TEMP_ACT_MIN && wdata_q[7:0] <= `TEMP_ACT_DEFAULT)
							temp_act <= wdata_q[7:0]; // RULE_21
					end
					`OFF_MEM_THRESH: begin
						mem_warm <= wdata_q[15:0]; // RULE_18
						mem_hot <= wdata_q[31:16];
					end
					`OFF_PKG_STATUS, `OFF_IRQ_EVENTS: s_axi_bresp <= 2'h0;
					default: s_axi_bresp <= 2'h2;
				endcase
			end
		end
	end

	// =====================================================
	// axi4-lite read channel
	reg [31:0] next_rdata;
	reg [1:0] next_rresp;
	always @* begin
		next_rresp = 2'h0;
		next_rdata = 32'h0;
		case ({s_axi_araddr[7:2], 2'h0})
			`OFF_PIN_CTRL: next_rdata = {29'h0, pin_ctrl};
			`OFF_DUTY_CTRL: next_rdata = {23'h0, fine_bit, 3'h0, duty_ctrl}; // RULE_15
			`OFF_CHIPSET_CTRL: next_rdata = {28'h0, chipset_ctrl};
			`OFF_PKG_STATUS: next_rdata = {25'h0, !proc_hot_n_out, lowest_perf_state,
				!thermal_trip_n, tcc_active, ext_hot, crit_log, crit};
			`OFF_TEMP_CFG: next_rdata = {24'h0, temp_act};
			`OFF_MEM_THRESH: next_rdata = {mem_hot, mem_warm};
			`OFF_MEM_STATUS: next_rdata = {28'h0, mem_sync, mem_throttle_level};
			`OFF_IRQ_EVENTS: next_rdata = {29'h0, irq_events};
			default: next_rresp = 2'h2;
		endcase
	end

	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= 2'h0;
		end else begin
			s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= next_rdata;
				s_axi_rresp <= next_rresp;
			end else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

endmodule // thermal_throttle_control

// [test/thermal_throttle_props.sv]
// port checker for the thermal throttle block
// assumes one clock domain on core_clk and the async active-low reset arst_n
`timescale 1ns/1ps
module thermal_throttle_props (
	input wire core_clk,
	input wire arst_n,
	input wire proc_hot_n_in,
	input wire proc_hot_n_oe_n,
	input wire thermal_trip_n,
	input wire package_shutdown,
	input wire damage_temp,
	input wire pkg_idle,
	input wire lowest_perf_state,
	input wire serial_link_en
);
	// ========
	// properties
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	a_trip_on_damage: assert property (damage_temp |-> ##[1:4] !thermal_trip_n)
		else $error("trip missed a damage temperature");
	a_trip_sticky: assert property (!thermal_trip_n |=> !thermal_trip_n)
		else $error("trip output released before reset");
	a_shutdown_trip: assert property (!thermal_trip_n [*2] |-> package_shutdown)
		else $error("package not shut down with trip");
	a_link_alive: assert property (serial_link_en)
		else $error("serial link disabled");
	// three samples cover the two synchroniser stages
	a_ext_response: assert property ((!proc_hot_n_in && proc_hot_n_oe_n) [*3] |->
		##[0:3] lowest_perf_state) else $error("outside hot not answered");
	a_ext_hold: assert property (lowest_perf_state && !proc_hot_n_in |=> lowest_perf_state)
		else $error("lowest perf dropped while pin held");
	a_defer_own: assert property (!proc_hot_n_oe_n [*4] ##0 !lowest_perf_state |=>
		!lowest_perf_state) else $error("outside hot seen while driving");
	a_idle_release: assert property (pkg_idle [*3] |-> proc_hot_n_oe_n)
		else $error("hot pin driven in package idle");
endmodule // thermal_throttle_props

bind thermal_throttle_control thermal_throttle_props u_props (.core_clk(core_clk),
	.arst_n(arst_n), .proc_hot_n_in(proc_hot_n_in), .proc_hot_n_oe_n(proc_hot_n_oe_n),
	.thermal_trip_n(thermal_trip_n), .package_shutdown(package_shutdown),
	.damage_temp(damage_temp), .pkg_idle(pkg_idle), .lowest_perf_state(lowest_perf_state),
	.serial_link_en(serial_link_en));

// [test/platform_model.sv]
// platform side of the hot pin and of the two memory heat pins
// assumes an open-drain hot pin with a board pull-up
`timescale 1ns/1ps
module platform_model (
	input wire hot_req,
	input wire [1:0] mem_req,
	input wire dut_out,
	input wire dut_oe_n,
	output wire pin,
	output wire [1:0] mem_pins
);
	// wired-and: a released pin floats to the pull-up level
	assign pin = !(hot_req || (!dut_oe_n && !dut_out));
	assign mem_pins = ~mem_req;
endmodule // platform_model

// [test/testbench.sv]
// self-checking bench for the thermal throttle block
// assumes the register map header and a 125 MHz core clock
`timescale 1ns/1ps
`include "thermal_throttle_map.vh"
module testbench;
	reg core_clk = 0, arst_n = 0;
	reg [7:0] awaddr = 0, araddr = 0;
	reg [31:0] wdata = 0, margin = 32'hffffffff;
	reg awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	reg hot_req = 0, damage = 0, idle = 0, sensor = 1;
	reg [1:0] mem_req = 0;
	reg [15:0] rank_power = 0;
	reg [19:0] duty = 0;
	wire awready, wready, bvalid, arready, rvalid, pin, hot_out, hot_oe_n, trip_n, hot_irq, lps;
	wire [1:0] bresp, rresp, mem_pins, mem_lvl;
	wire [31:0] rdata;
	wire [3:0] gate;
	integer num_errors = 0, checks = 0;
	logic [31:0] q;
	logic [1:0] r;
	int g0, g1, d, c;
	always #4 core_clk = ~core_clk;
	thermal_throttle_control DUT (.core_clk(core_clk), .arst_n(arst_n), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.proc_hot_n_in(pin), .proc_hot_n_out(hot_out), .proc_hot_n_oe_n(hot_oe_n),
		.thermal_trip_n(trip_n), .hot_irq(hot_irq), .core_margin(margin), .damage_temp(damage),
		.adaptive_en(1'b1), .pkg_idle(idle), .ext_mem_temp_n(mem_pins),
		.mem_sensor_present(sensor), .rank_power(rank_power), .core_duty_ctrl(duty),
		.core_clk_gate(gate), .lowest_perf_state(lps), .mem_throttle_level(mem_lvl),
		.serial_link_en(), .package_shutdown());
	platform_model u_platform (.hot_req(hot_req), .mem_req(mem_req), .dut_out(hot_out),
		.dut_oe_n(hot_oe_n), .pin(pin), .mem_pins(mem_pins));
	// ========
	// tasks
	task complete_run;
		$display("num_errors %0d checks %0d", num_errors, checks);
		if (num_errors == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask
	task tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	// one access at a time; each channel is held until its own ready
	task bus(input bit w, input [7:0] a, input [31:0] dw);
		int n;
		n = 0;
		@(posedge core_clk);
		if (w) begin
			awaddr <= a;
			wdata <= dw;
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			bready <= 1'b1;
		end else begin
			araddr <= a;
			arvalid <= 1'b1;
			rready <= 1'b1;
		end
		do begin
			@(posedge core_clk);
			n++;
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (arready) arvalid <= 1'b0;
			if (bvalid && bready) begin
				bready <= 1'b0;
				r = bresp;
			end
			if (rvalid && rready) begin
				rready <= 1'b0;
				r = rresp;
				q = rdata;
			end
		end while (!(bvalid && bready || rvalid && rready) && n < 200);
		if (n >= 200) begin
			num_errors++;
			$display("[ERR] %0t bus timeout", $time);
			complete_run;
		end
	endtask
	task rd(input [7:0] a, input [31:0] e, input [31:0] m);
		bus(0, a, 0);
		chk(q & m, e);
	endtask
	function logic [1:0] cur(input int s);
		case (s)
			0: return {1'b0, hot_out};
			1: return {1'b0, lps};
			2: return {1'b0, trip_n};
			3: return {1'b0, hot_irq};
			4: return mem_lvl;
			default: return {1'b0, hot_oe_n};
		endcase
	endfunction
	task wt(input int s, input logic [1:0] v);
		int n;
		n = 0;
		while (cur(s) !== v && n < 3000) begin
			@(negedge core_clk);
			n++;
		end
		chk(cur(s), v);
		if (n >= 3000) complete_run;
		@(posedge core_clk);
	endtask
	// gated slots counted over eight whole modulation periods
	task gm;
		g0 = 0;
		g1 = 0;
		tick(4);
		repeat (64) begin
			@(negedge core_clk);
			g0 += gate[0];
			g1 += gate[1];
		end
		@(posedge core_clk);
	endtask
	function int eg(input int k);
		return 8 * (8 - k);
	endfunction
	// ========
	// main sequence
	initial begin
		void'($urandom(87));
		tick(20);
		arst_n <= 1'b1;
		rd(`OFF_PIN_CTRL, 32'h0, 32'h7);
		rd(`OFF_TEMP_CFG, 32'h64, 32'hff);
		rd(`OFF_DUTY_CTRL, 32'h0, 32'h100);
		bus(1, `OFF_TEMP_CFG, 32'h50);
		bus(1, `OFF_TEMP_CFG, 32'h4f);
		rd(`OFF_TEMP_CFG, 32'h50, 32'hff);
		margin[15:8] <= 8'h15;
		tick(4);
		rd(`OFF_PKG_STATUS, 32'h0, 32'h8);
		margin[15:8] <= 8'h14;
		tick(4);
		rd(`OFF_PKG_STATUS, 32'h8, 32'h8);
		margin[15:8] <= 8'hff;
		bus(1, `OFF_TEMP_CFG, 32'h64);
		bus(1, 8'h20, 32'h0);
		chk(r, 2'h2);
		$display("registers done");
		bus(1, `OFF_PIN_CTRL, 32'h2);
		margin[7:0] <= 8'h00;
		wt(0, 0);
		idle <= 1'b1;
		wt(5, 1);
		idle <= 1'b0;
		wt(5, 0);
		hot_req <= 1'b1;
		tick(40);
		chk(lps, 0);
		margin[7:0] <= 8'hff;
		wt(1, 1);
		wt(3, 1);
		rd(`OFF_IRQ_EVENTS, 32'h1, 32'h1);
		bus(1, `OFF_IRQ_EVENTS, 32'h7);
		hot_req <= 1'b0;
		wt(1, 0);
		rd(`OFF_IRQ_EVENTS, 32'h2, 32'h2);
		bus(1, `OFF_PIN_CTRL, 32'h1);
		margin[7:0] <= 8'h00;
		tick(50);
		chk(hot_oe_n, 1);
		duty[4:0] <= 5'h1e;
		gm;
		chk(g0, eg(`TCC_DUTY_CODE));
		tick(1100);
		rd(`OFF_PKG_STATUS, 32'h3, 32'h3);
		margin[7:0] <= 8'hff;
		tick(10);
		rd(`OFF_PKG_STATUS, 32'h2, 32'h2);
		bus(1, `OFF_PKG_STATUS, 32'h2);
		rd(`OFF_PKG_STATUS, 32'h0, 32'h2);
		$display("hot pin and critical done");
		repeat (4) begin
			d = 1 + $urandom % 7;
			c = 1 + $urandom % 7;
			duty[4:0] <= {1'b1, d[2:0], 1'b0};
			gm;
			chk(g0, eg(d));
			chk(g1, 0);
			bus(1, `OFF_CHIPSET_CTRL, {28'h0, 1'b1, c[2:0]});
			gm;
			chk(g0, eg(c));
			chk(g1, eg(c));
			bus(1, `OFF_CHIPSET_CTRL, 32'h0);
		end
		$display("modulation done");
		for (int i = 0; i < 4; i++) begin
			mem_req <= i[1:0];
			tick(3);
			wt(4, {i[1], i[0] & ~i[1]});
		end
		mem_req <= 2'h0;
		sensor <= 1'b0;
		bus(1, `OFF_MEM_THRESH, 32'h80004000);
		rank_power <= 16'h5000;
		wt(4, 1);
		rank_power <= 16'h9000;
		wt(4, 2);
		$display("memory throttle done");
		damage <= 1'b1;
		wt(2, 0);
		$display("trip done");
		complete_run;
	end
endmodule // testbench
